// ===== inc/ebsc_pkg.sv
// constants and types of the external bus strobe control block
// Notes on behaviour
// [R1] software picks per-byte write strobes or common strobe plus lane selects
// [R2] read strobe low during a read; far side drives data then
// [R3] per-byte mode, 32-bit bus: byte strobe k low writes byte 4n+k
// [R4] per-byte mode, 16-bit bus: strobe 0 even address, strobe 1 odd
// [R5] common mode: write while common strobe low; lane k selects 4n+k
// [R6] common mode, 16-bit bus: lane 0 even address, lane 1 odd
// [R7] multiplexed bus: lane 0/2 selects share pins with data bits 0/1
// [R8] multiplexed bus: address latch strobe marks the address phase
// [R9] stay released while the release request input is held low
// [R10] release acknowledge low for the whole released state
// [R11] low wait input stretches the current bus cycle
// [R12] multiplexed bus: low address bits first, then low data bits
// [R13] four active-low region selects, one asserted per access
package ebsc_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 5000;
  localparam int unsigned STRB_MIN_NS    = 15;
  localparam int unsigned STRB_MIN_CYC   = (STRB_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0]  STRB_LAST      = 4'(STRB_MIN_CYC - 1);
  localparam int unsigned ADDR_W         = 24;
  localparam int unsigned DATA_W         = 32;
  localparam int unsigned LANES          = 4;
  localparam int unsigned REGION_LSB     = 22;
  localparam int unsigned MUX_ADDR_W     = 8;
  localparam int unsigned SYNC_W         = 36;
  localparam logic [3:0]  LANES_NONE     = 4'h0;
  localparam logic [3:0]  LANES_LOW_MASK = 4'h3;
  localparam logic [3:0]  CNT_RESET      = 4'h0;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_ALE  = 5'h02,
    ST_STRB = 5'h04,
    ST_END  = 5'h08,
    ST_HOLD = 5'h10
  } ebsc_state_e;

  typedef struct packed
  {
    ebsc_state_e        st;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [LANES-1:0]   lanes;
    logic               write;
    logic               per_byte;
    logic               wide;
    logic               mux;
    logic [3:0]         cnt;
    logic               resp;
  } ebsc_regs_s;
endpackage

// ===== core/ebsc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ebsc_sync2
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // pins idle high, so reset to all ones avoids a false hold or wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== core/ebsc_bus_ctrl.sv
// external bus strobe control: chip selects, strobes, latch, release, wait
`timescale 1ns/1ps
`default_nettype none
module ebsc_bus_ctrl
  import ebsc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              per_byte_mode,
  input  wire logic              bus_wide32,
  input  wire logic              mux_mode,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [LANES-1:0]  req_lanes,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   resp_valid,
  output logic [DATA_W-1:0]      resp_rdata,
  output logic [3:0]             region_select_outputs_n,
  output logic                   read_strobe_n,
  output logic                   byte0_write_strobe_n,
  output logic                   byte1_write_strobe_n,
  output logic                   byte2_write_strobe_n,
  output logic                   byte3_write_strobe_n,
  output logic                   common_write_strobe_n,
  output logic                   lane0_select_n,
  output logic                   lane1_select_n,
  output logic                   lane2_select_n,
  output logic                   lane3_select_n,
  output logic                   addr_latch_en,
  output logic                   ctrl_oe,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe,
  input  wire logic [DATA_W-1:0] data_in,
  output logic [1:0]             lane_data_out,
  output logic                   lane_data_oe,
  input  wire logic [1:0]        lane_data_in,
  input  wire logic              bus_release_req_n,
  output logic                   bus_release_ack_n,
  input  wire logic              wait_n
);
  // ==========================================================
  // reset release and pin synchronisers
  logic              rst_meta_r;
  logic              rst_n;
  logic [SYNC_W-1:0] sync_q;
  logic [DATA_W-1:0] din_s;
  logic [1:0]        lane_din_s;
  logic              hold_req_s;
  logic              wait_s;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  ebsc_sync2 #(.WIDTH(SYNC_W)) u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({lane_data_in, data_in, wait_n, bus_release_req_n}),
    .q     (sync_q)
  );

  assign lane_din_s = sync_q[SYNC_W-1 -: 2];
  assign din_s      = sync_q[DATA_W+1:2];
  assign wait_s     = sync_q[1];
  assign hold_req_s = sync_q[0];

  // ==========================================================
  // sequencer
  ebsc_regs_s r;
  ebsc_regs_s r_nxt;

  always_comb
  begin
    r_nxt      = r;
    r_nxt.resp = 1'b0;
    case (r.st)
      ST_IDLE:
      begin
        // release wins over a pending request so the far master is not starved
        if (!hold_req_s)
          r_nxt.st = ST_HOLD; // R9
        else if (req_valid)
        begin
          r_nxt.addr     = req_addr;
          r_nxt.wdata    = req_wdata;
          r_nxt.write    = req_write;
          r_nxt.per_byte = per_byte_mode; // R1
          r_nxt.wide     = bus_wide32;
          r_nxt.mux      = mux_mode;
          // 16-bit bus only has lanes 0 and 1
          r_nxt.lanes    = bus_wide32 ? req_lanes : (req_lanes & LANES_LOW_MASK); // R4 R6
          r_nxt.cnt      = CNT_RESET;
          r_nxt.st       = mux_mode ? ST_ALE : ST_STRB; // R8
        end
      end
      ST_ALE:
        r_nxt.st = ST_STRB; // R12
      ST_STRB:
      begin
        if (r.cnt != STRB_LAST)
          r_nxt.cnt = r.cnt + 4'h1;
        else if (wait_s)
          r_nxt.st = ST_END; // R11
      end
      ST_END:
      begin
        // synced data lags the pins by two cycles: this is strobe-time data
        if (!r.write)
        begin
          r_nxt.rdata = din_s; // R2
          if (r.mux)
            r_nxt.rdata[1:0] = lane_din_s; // R7
        end
        r_nxt.resp = 1'b1;
        r_nxt.st   = ST_IDLE;
      end
      ST_HOLD:
      begin
        if (hold_req_s)
          r_nxt.st = ST_IDLE; // R9
      end
      default:
        r_nxt.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '{st: ST_IDLE, lanes: LANES_NONE, cnt: CNT_RESET, default: '0};
    end
    else
    begin
      r <= r_nxt;
    end
  end

  // ==========================================================
  // pin drive
  logic            active;
  logic            strobing;
  logic [3:0]      byte_n;
  logic [3:0]      sel_n;

  assign active   = (r.st == ST_ALE) || (r.st == ST_STRB) || (r.st == ST_END);
  assign strobing = (r.st == ST_STRB);

  assign req_ready  = (r.st == ST_IDLE) && hold_req_s;
  assign resp_valid = r.resp;
  assign resp_rdata = r.rdata;

  // released bus: every control and data driver lets go
  assign ctrl_oe           = (r.st != ST_HOLD);
  assign bus_release_ack_n = (r.st != ST_HOLD); // R10

  always_comb
  begin
    region_select_outputs_n = 4'hF;
    if (active)
      region_select_outputs_n[r.addr[ADDR_W-1:REGION_LSB]] = 1'b0; // R13
  end

  assign read_strobe_n = !(strobing && !r.write); // R2

  assign byte_n = (strobing && r.write && r.per_byte) ? ~r.lanes : 4'hF; // R3 R4
  assign byte0_write_strobe_n = byte_n[0];
  assign byte1_write_strobe_n = byte_n[1];
  assign byte2_write_strobe_n = byte_n[2];
  assign byte3_write_strobe_n = byte_n[3];

  assign common_write_strobe_n = !(strobing && r.write && !r.per_byte); // R5
  assign sel_n = (active && !r.per_byte) ? ~r.lanes : 4'hF; // R5 R6
  // on the multiplexed bus lanes 0 and 2 leave on the shared pins
  assign lane0_select_n = r.mux ? 1'b1 : sel_n[0]; // R7
  assign lane1_select_n = sel_n[1];
  assign lane2_select_n = r.mux ? 1'b1 : sel_n[2]; // R7
  assign lane3_select_n = sel_n[3];

  assign addr_latch_en = (r.st == ST_ALE) && r.mux; // R8

  always_comb
  begin
    addr_out      = r.addr;
    data_out      = r.wdata;
    data_oe       = active && r.write;
    lane_data_out = r.wdata[1:0];
    lane_data_oe  = active && r.mux && r.write;
    if (r.st == ST_ALE)
    begin
      data_out[MUX_ADDR_W-1:0] = r.addr[MUX_ADDR_W-1:0]; // R12
      data_oe                  = 1'b1;
      lane_data_out            = {sel_n[2], sel_n[0]}; // R7
      lane_data_oe             = !r.per_byte;
    end
  end

  // ==========================================================
  // checks
  property p_read_low;
    @(posedge clk) disable iff (!rst_n)
    (r.st == ST_IDLE && hold_req_s && req_valid && !req_write && !mux_mode)
      |=> !read_strobe_n [*3];
  endproperty
  a_read_low: assert property (p_read_low) else $error("read strobe not low"); // R2

  property p_per_byte32;
    @(posedge clk) disable iff (!rst_n)
    (strobing && r.write && r.per_byte && r.wide)
      |-> {byte3_write_strobe_n, byte2_write_strobe_n, byte1_write_strobe_n,
           byte0_write_strobe_n} == ~r.lanes && common_write_strobe_n;
  endproperty
  a_per_byte32: assert property (p_per_byte32) else $error("byte strobe mismatch"); // R3

  property p_per_byte16;
    @(posedge clk) disable iff (!rst_n)
    (r.per_byte && !r.wide) |-> byte2_write_strobe_n && byte3_write_strobe_n;
  endproperty
  a_per_byte16: assert property (p_per_byte16) else $error("upper strobe on narrow bus"); // R4

  property p_common;
    @(posedge clk) disable iff (!rst_n)
    (strobing && r.write && !r.per_byte && !r.mux)
      |-> !common_write_strobe_n && byte_n == 4'hF
          && {lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n} == ~r.lanes;
  endproperty
  a_common: assert property (p_common) else $error("common strobe mismatch"); // R5

  property p_common16;
    @(posedge clk) disable iff (!rst_n)
    (!r.per_byte && !r.wide) |-> lane2_select_n && lane3_select_n;
  endproperty
  a_common16: assert property (p_common16) else $error("upper lane on narrow bus"); // R6

  property p_mux_share;
    @(posedge clk) disable iff (!rst_n)
    (addr_latch_en && !r.per_byte && r.write)
      |-> lane_data_out == {~r.lanes[2], ~r.lanes[0]}
          ##1 lane_data_out == r.wdata[1:0] && lane_data_oe;
  endproperty
  a_mux_share: assert property (p_mux_share) else $error("shared pin phase wrong"); // R7

  property p_ale;
    @(posedge clk) disable iff (!rst_n)
    $rose(addr_latch_en) |-> data_out[7:0] == r.addr[7:0] ##1 !addr_latch_en && strobing;
  endproperty
  a_ale: assert property (p_ale) else $error("latch strobe sequence wrong"); // R8 R12

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (r.st == ST_IDLE && !hold_req_s) |=> !bus_release_ack_n && !data_oe && !ctrl_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("release not acknowledged"); // R9 R10

  property p_hold_stay;
    @(posedge clk) disable iff (!rst_n)
    (!bus_release_ack_n && !hold_req_s) |=> !bus_release_ack_n;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("left release early"); // R9 R10

  property p_wait;
    @(posedge clk) disable iff (!rst_n)
    (strobing && !wait_s) |=> strobing;
  endproperty
  a_wait: assert property (p_wait) else $error("wait ignored"); // R11

  property p_region;
    @(posedge clk) disable iff (!rst_n)
    active |-> $countones(~region_select_outputs_n) == 1
               && !region_select_outputs_n[r.addr[23:22]];
  endproperty
  a_region: assert property (p_region) else $error("region select wrong"); // R13

  c_read:  cover property (@(posedge clk) disable iff (!rst_n) resp_valid && !r.write);
  c_write: cover property (@(posedge clk) disable iff (!rst_n) resp_valid && r.write && r.mux);
  c_hold:  cover property (@(posedge clk) disable iff (!rst_n) !bus_release_ack_n);
  c_wait:  cover property (@(posedge clk) disable iff (!rst_n) strobing && !wait_s ##1 strobing);
endmodule
`default_nettype wire

// ===== test/ebsc_mem_model.sv
// far-side memory model: read data and wait requests
`timescale 1ns/1ps
`default_nettype none
module ebsc_mem_model
#(
  parameter logic [31:0] RD_WORD = 32'hA5C3_5A3C
)
(
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        read_strobe_n,
  output logic [31:0]      data_in,
  output logic [1:0]       lane_data_in,
  output logic             wait_n
);
  logic [2:0] wcnt;
  // released lines show the inverse word, so stale data never passes
  assign data_in      = read_strobe_n ? ~RD_WORD : RD_WORD;
  assign lane_data_in = data_in[1:0];
  always @(posedge clk)
    wcnt <= read_strobe_n ? 3'h0 : wcnt + 3'h1;
  // slow device holds wait for the first four strobe cycles
  assign wait_n = !(slow && !read_strobe_n && wcnt < 3'h4);
endmodule
`default_nettype wire

// ===== test/tb_external_bus_strobe_control.sv
// testbench: strobes, selects, latch, release and wait
`timescale 1ns/1ps
`default_nettype none
module tb_external_bus_strobe_control;
  import ebsc_pkg::*;
  localparam logic [31:0] RD_WORD = 32'hA5C3_5A3C;
  logic              clk, rst_b, pb, w32, mx, req_valid, req_write, slow, rel_n;
  logic              req_ready, resp_valid, rd_n, cw_n, ale, ctrl_oe, data_oe;
  logic              lane_oe, ack_n, wait_n;
  logic [3:0]        b_n, l_n, rs_n, req_lanes, rs_r;
  logic [1:0]        lane_do, lane_di;
  logic [ADDR_W-1:0] req_addr, addr_o;
  logic [DATA_W-1:0] req_wdata, resp_rdata, data_out, data_in;
  logic [9:0]        lo_r;
  logic              ale_ok, pin_ok;
  int                num_errors, num_checks, cyc, ale_cnt;

  ebsc_bus_ctrl dut_u
  (
    .clk(clk), .rst_b(rst_b), .per_byte_mode(pb), .bus_wide32(w32), .mux_mode(mx),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .region_select_outputs_n(rs_n),
    .read_strobe_n(rd_n), .byte0_write_strobe_n(b_n[0]), .byte1_write_strobe_n(b_n[1]),
    .byte2_write_strobe_n(b_n[2]), .byte3_write_strobe_n(b_n[3]),
    .common_write_strobe_n(cw_n), .lane0_select_n(l_n[0]), .lane1_select_n(l_n[1]),
    .lane2_select_n(l_n[2]), .lane3_select_n(l_n[3]), .addr_latch_en(ale),
    .ctrl_oe(ctrl_oe), .addr_out(addr_o), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .lane_data_out(lane_do), .lane_data_oe(lane_oe),
    .lane_data_in(lane_di), .bus_release_req_n(rel_n), .bus_release_ack_n(ack_n),
    .wait_n(wait_n)
  );

  ebsc_mem_model #(.RD_WORD(RD_WORD)) mem_u
  (
    .clk(clk), .slow(slow), .read_strobe_n(rd_n), .data_in(data_in),
    .lane_data_in(lane_di), .wait_n(wait_n)
  );

  // ==========================================================
  // helpers
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one access; pins are watched at falling edges where they are settled
  task automatic run(input logic [2:0] m, input logic w, input logic [23:0] a,
                     input logic [3:0] ln);
    int i;
    lo_r = '0;
    rs_r = 4'hF;
    cyc = 0;
    ale_cnt = 0;
    ale_ok = 1'b1;
    pin_ok = 1'b1;
    i = 0;
    @(posedge clk);
    {pb, w32, mx} <= m;
    req_write <= w;
    req_addr <= a;
    req_lanes <= ln;
    req_valid <= 1'b1;
    // request stands until an edge that sees ready high
    @(posedge clk);
    while (i < 50 && req_ready !== 1'b1)
    begin
      @(posedge clk);
      i++;
    end
    req_valid <= 1'b0;
    while (cyc < 60 && resp_valid !== 1'b1)
    begin
      @(negedge clk);
      cyc++;
      lo_r |= ~{rd_n, cw_n, b_n, l_n};
      if ({rd_n, cw_n, b_n} != 6'h3F) rs_r = rs_n;
      if (rs_n !== 4'hF) pin_ok &= addr_o === a;
      if ({cw_n, b_n} != 5'h1F)
        pin_ok &= data_out[15:0] === req_wdata[15:0] && data_oe
                  && (!mx || (lane_do === req_wdata[1:0] && lane_oe));
      if (ale === 1'b1)
      begin
        ale_cnt++;
        ale_ok &= data_out[7:0] === a[7:0] && lane_do === ~{ln[2], ln[0]};
      end
    end
  endtask

  task automatic judge(input logic [9:0] exp_lo, input int exp_cyc, input logic [23:0] a);
    chk(lo_r === exp_lo, "strobe or lane pattern");
    chk(rs_r === ~(4'h1 << a[23:22]), "region select");
    chk(exp_cyc == 0 || cyc == exp_cyc, "access length");
    chk(pin_ok, "write data on pins");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_per_byte32();
    run(3'b110, 1'b1, 24'h000004, 4'h5);
    judge({2'b00, 4'h5, 4'h0}, 5, 24'h000004);
    $display("test per_byte32 done");
  endtask

  task automatic t_common32();
    run(3'b010, 1'b1, 24'h400001, 4'hA);
    judge({2'b01, 4'h0, 4'hA}, 5, 24'h400001);
    $display("test common32 done");
  endtask

  task automatic t_narrow();
    run(3'b100, 1'b1, 24'h800003, 4'h2);
    judge({2'b00, 4'h2, 4'h0}, 5, 24'h800003);
    run(3'b000, 1'b1, 24'hC00002, 4'h1);
    judge({2'b01, 4'h0, 4'h1}, 5, 24'hC00002);
    $display("test narrow done");
  endtask

  task automatic t_read_wait();
    run(3'b110, 1'b0, 24'h000010, 4'hF);
    judge({2'b10, 8'h00}, 5, 24'h000010);
    chk(resp_rdata === RD_WORD, "read data");
    slow <= 1'b1;
    run(3'b110, 1'b0, 24'h400020, 4'hF);
    slow <= 1'b0;
    chk(cyc > 5 && cyc < 60, "wait did not stretch the cycle");
    chk(resp_rdata === RD_WORD, "read data after wait");
    judge({2'b10, 8'h00}, 0, 24'h400020);
    $display("test read_wait done");
  endtask

  task automatic t_mux();
    run(3'b011, 1'b1, 24'h4000A7, 4'hF);
    judge({2'b01, 4'h0, 4'hA}, 6, 24'h4000A7);
    chk(ale_cnt == 1 && ale_ok, "address phase");
    $display("test mux done");
  endtask

  // reset dropped in the middle of a multiplexed write, then a multiplexed read
  task automatic t_reset();
    @(posedge clk);
    {pb, w32, mx} <= 3'b011;
    req_write <= 1'b1;
    req_addr <= 24'h400004;
    req_lanes <= 4'hF;
    req_valid <= 1'b1;
    repeat (3) @(posedge clk);
    req_valid <= 1'b0;
    rst_b <= 1'b0;
    @(negedge clk);
    chk(rd_n && cw_n && &b_n && &l_n && &rs_n && ack_n && ctrl_oe && !ale && !data_oe
        && !resp_valid, "outputs not idle in reset");
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    chk(resp_rdata === 32'h0, "read data not cleared");
    run(3'b011, 1'b0, 24'h400004, 4'hF);
    judge({2'b10, 4'h0, 4'hA}, 6, 24'h400004);
    chk(resp_rdata === RD_WORD, "multiplexed read data");
    $display("test reset done");
  endtask

  task automatic t_release();
    int n;
    @(posedge clk);
    rel_n <= 1'b0;
    for (n = 0; n < 10 && ack_n !== 1'b0; n++) @(negedge clk);
    chk(ack_n === 1'b0 && ctrl_oe === 1'b0, "release not entered");
    for (n = 0; n < 20; n++)
    begin
      @(negedge clk);
      chk(ack_n === 1'b0 && req_ready === 1'b0, "release left early");
    end
    @(posedge clk);
    rel_n <= 1'b1;
    for (n = 0; n < 10 && ack_n !== 1'b1; n++) @(negedge clk);
    chk(ack_n === 1'b1 && ctrl_oe === 1'b1, "release not left");
    run(3'b110, 1'b1, 24'h800008, 4'h3);
    judge({2'b00, 4'h3, 4'h0}, 5, 24'h800008);
    $display("test release done");
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // all tests need well under a thousand cycles
  initial
  begin
    #20000;
    num_errors++;
    end_sim();
  end

  initial
  begin
    {rst_b, pb, w32, mx, req_valid, req_write, slow, rel_n} = 8'h01;
    req_addr = '0;
    req_lanes = 4'h0;
    req_wdata = 32'h1234_56C9;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    t_per_byte32();
    t_common32();
    t_narrow();
    t_read_wait();
    t_mux();
    t_release();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
